/* File: rtl/spsp_defs.vh */
// Constants for the spectrometer serial status port.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef SPSP_DEFS_VH
`define SPSP_DEFS_VH

// ----------------------------------------
// Clock and serial timing
// ----------------------------------------
`define SPSP_CLK_PERIOD_NS   50
`define SPSP_SCLK_MIN_NS     100
`define SPSP_SCLK_MAX_NS     1000
`define SPSP_LEAD_NS         4000
`define SPSP_GAP_NS          5000

// ----------------------------------------
// Byte framing
// ----------------------------------------
`define SPSP_BYTE_BITS       8
`define SPSP_BIT_CNT_W       3
`define SPSP_BIT_LAST        3'h7
`define SPSP_BIT_MSB         7
`define SPSP_IDLE_BYTE       8'h00
`define SPSP_SCLK_HIST_IDLE  3'h0
`define SPSP_CS_HIST_IDLE    2'h3

// ----------------------------------------
// Indicator pulse timing
// ----------------------------------------
`define SPSP_BLINK_NS        250000000
`define SPSP_BLINK_W         24

`endif

/* File: rtl/spsp_blink.v */
// Free running square wave used to pulse the red indicator.
// Assumes sys_clk at the rate given in the constants header.
`timescale 1ns/10ps
`default_nettype none
`include "spsp_defs.vh"

module spsp_blink #(
  parameter HALF_CYCLES = `SPSP_BLINK_NS / `SPSP_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  // Square wave
  output reg  wave_ff
);

  reg [`SPSP_BLINK_W-1:0] cnt_ff;
  wire                    cnt_end;

  assign cnt_end = (cnt_ff == HALF_CYCLES[`SPSP_BLINK_W-1:0] - 1'b1);

  // ----------------------------------------
  // Half period counter
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff  <= {`SPSP_BLINK_W{1'b0}};
      wave_ff <= 1'b0;
    end else if (cnt_end) begin
      cnt_ff  <= {`SPSP_BLINK_W{1'b0}};
      wave_ff <= ~wave_ff;
    end else begin
      cnt_ff  <= cnt_ff + 1'b1;
    end
  end

endmodule // spsp_blink

`default_nettype wire

/* File: rtl/spsp_port.v */
// Serial peripheral port of the spectrometer with state indicators.
// Assumes serial pins synchronous to sys_clk (sampled in its domain).
//
// What this block does
// - Four lines: data in, out, clock, select.
// - Mode 1: idle low, launch rise, sample fall.
// - Low reset input returns initial state.
// - Both lit uninitialised; green alone when idle.
// - Exposure green plus red pulse; bootloader red pulse.
// - Payload carries common command layer messages.
`timescale 1ns/10ps
`default_nettype none
`include "spsp_defs.vh"

module spsp_port #(
  parameter BYTE_BITS   = `SPSP_BYTE_BITS,
  parameter BLINK_HALF  = `SPSP_BLINK_NS / `SPSP_CLK_PERIOD_NS
) (
  // Clock and device reset
  input  wire                 sys_clk,
  input  wire                 rst_n,
  // Serial pins
  input  wire                 spi_sclk,
  input  wire                 spi_cs_n,
  input  wire                 spi_pico,
  output reg                  spi_poci_ff,
  output reg                  spi_poci_oe_ff,
  // Message layer, received byte
  output reg  [BYTE_BITS-1:0] rx_byte_ff,
  output reg                  rx_valid_ff,
  // Message layer, byte to send
  input  wire [BYTE_BITS-1:0] tx_byte,
  output reg                  tx_taken_ff,
  // Frame markers
  output reg                  frame_start_ff,
  output reg                  frame_end_ff,
  // Device state for indicators
  input  wire                 dev_ready,
  input  wire                 dev_exposing,
  input  wire                 dev_boot,
  output reg                  led_red_ff,
  output reg                  led_green_ff
);

  // Indicator states, one-hot
  localparam [3:0] ST_INIT = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_EXPO = 4'h4;
  localparam [3:0] ST_BOOT = 4'h8;

  reg [2:0]               sclk_sh_ff;
  reg [1:0]               cs_sh_ff;
  reg [BYTE_BITS-1:0]     rx_sh_ff;
  reg [BYTE_BITS-1:0]     tx_sh_ff;
  reg [`SPSP_BIT_CNT_W-1:0] bit_cnt_ff;
  reg [3:0]               state_ff;
  reg [3:0]               nxt_state;
  wire                    blink;
  wire                    sclk_rise;
  wire                    sclk_fall;
  wire                    cs_fall;
  wire                    cs_rise;
  wire                    active;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Level went high between the older and newer tap
  function edge_up;
    input now_lvl;
    input old_lvl;
    edge_up = now_lvl & ~old_lvl;
  endfunction

  // Level went low between the older and newer tap
  function edge_down;
    input now_lvl;
    input old_lvl;
    edge_down = ~now_lvl & old_lvl;
  endfunction

  // New bit enters at the low end, so the first bit ends as MSB
  function [BYTE_BITS-1:0] shift_in;
    input [BYTE_BITS-1:0] cur;
    input                 bit_in;
    shift_in = {cur[BYTE_BITS-2:0], bit_in};
  endfunction

  // ----------------------------------------
  // Edge detection on pins
  // ----------------------------------------
  // Pins are synchronous; an extra stage only gives edge history
  assign sclk_rise = edge_up(sclk_sh_ff[1], sclk_sh_ff[2]);
  assign sclk_fall = edge_down(sclk_sh_ff[1], sclk_sh_ff[2]);
  assign cs_fall   = edge_down(cs_sh_ff[0], cs_sh_ff[1]);
  assign cs_rise   = edge_up(cs_sh_ff[0], cs_sh_ff[1]);
  assign active    = ~cs_sh_ff[0];

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      // History reset to idle pin levels: no false edge after reset
      sclk_sh_ff <= `SPSP_SCLK_HIST_IDLE;
      cs_sh_ff   <= `SPSP_CS_HIST_IDLE;
    end else begin
      sclk_sh_ff <= {sclk_sh_ff[1:0], spi_sclk};
      cs_sh_ff   <= {cs_sh_ff[0], spi_cs_n};
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  // Launch on rise, sample on fall; relies on slow serial clock
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_sh_ff       <= `SPSP_IDLE_BYTE;
      tx_sh_ff       <= `SPSP_IDLE_BYTE;
      bit_cnt_ff     <= {`SPSP_BIT_CNT_W{1'b0}};
      rx_byte_ff     <= `SPSP_IDLE_BYTE;
      rx_valid_ff    <= 1'b0;
      tx_taken_ff    <= 1'b0;
      spi_poci_ff    <= 1'b0;
      spi_poci_oe_ff <= 1'b0;
      frame_start_ff <= 1'b0;
      frame_end_ff   <= 1'b0;
    end else begin
      rx_valid_ff    <= 1'b0;
      tx_taken_ff    <= 1'b0;
      frame_start_ff <= cs_fall;
      frame_end_ff   <= cs_rise;
      // Pin released whenever select is high, so a shared line stays free
      spi_poci_oe_ff <= active;
      if (cs_fall) begin
        // Lead time is long, so byte is loaded before first edge
        bit_cnt_ff  <= {`SPSP_BIT_CNT_W{1'b0}};
        tx_sh_ff    <= tx_byte;
        tx_taken_ff <= 1'b1;
      end else if (active && sclk_rise) begin
        // Leading edge puts the next bit out, MSB first
        spi_poci_ff <= tx_sh_ff[`SPSP_BIT_MSB];
        tx_sh_ff    <= shift_in(tx_sh_ff, 1'b0);
      end else if (active && sclk_fall) begin
        rx_sh_ff   <= shift_in(rx_sh_ff, spi_pico);
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
        if (bit_cnt_ff == `SPSP_BIT_LAST) begin
          // Whole byte in: hand up and reload for the next
          rx_byte_ff  <= shift_in(rx_sh_ff, spi_pico);
          rx_valid_ff <= 1'b1;
          tx_sh_ff    <= tx_byte;
          tx_taken_ff <= 1'b1;
        end
      end else if (cs_rise) begin
        // Partial byte is dropped at frame end
        bit_cnt_ff  <= {`SPSP_BIT_CNT_W{1'b0}};
        spi_poci_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Indicator state machine
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_INIT: if (dev_boot) nxt_state = ST_BOOT;
               else if (dev_ready) nxt_state = ST_IDLE;
      ST_IDLE: if (dev_boot) nxt_state = ST_BOOT;
               else if (dev_exposing) nxt_state = ST_EXPO;
      ST_EXPO: if (dev_boot) nxt_state = ST_BOOT;
               else if (!dev_exposing) nxt_state = ST_IDLE;
      ST_BOOT: if (!dev_boot) nxt_state = dev_ready ? ST_IDLE : ST_INIT;
      default: nxt_state = ST_INIT;
    endcase
  end

  spsp_blink #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wave_ff (blink)
  );

  // Lamps registered from next state; reset shows the uninitialised pair
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff     <= ST_INIT;
      led_red_ff   <= 1'b1;
      led_green_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      case (nxt_state)
        ST_INIT: begin
          led_red_ff   <= 1'b1;
          led_green_ff <= 1'b1;
        end
        ST_IDLE: begin
          led_red_ff   <= 1'b0;
          led_green_ff <= 1'b1;
        end
        ST_EXPO: begin
          led_red_ff   <= blink;
          led_green_ff <= 1'b1;
        end
        ST_BOOT: begin
          led_red_ff   <= blink;
          led_green_ff <= 1'b0;
        end
        default: begin
          led_red_ff   <= 1'b1;
          led_green_ff <= 1'b1;
        end
      endcase
    end
  end

endmodule // spsp_port

`default_nettype wire

/* File: tb/spsp_port_checker.sv */
// Assertions on the ports of the serial status port.
// Assumes a bind onto spsp_port with the blink parameter passed on.
`timescale 1ns/10ps
`default_nettype none
module spsp_port_checker #(
  parameter BLINK_HALF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_poci_ff,
  input wire logic spi_poci_oe_ff,
  // Strobes and indicators
  input wire logic rx_valid_ff,
  input wire logic frame_start_ff,
  input wire logic frame_end_ff,
  input wire logic dev_boot,
  input wire logic led_red_ff,
  input wire logic led_green_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Driver follows select, with a short lag
  property p_oe_on; $fell(spi_cs_n) |-> ##[1:3] spi_poci_oe_ff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("poci not driven");
  property p_oe_off; spi_cs_n [*4] |-> !spi_poci_oe_ff; endproperty
  a_oe_off: assert property (p_oe_off) else $error("poci driven idle");
  // While selected, output holds once the serial clock has been steady for six cycles
  property p_hold; (!spi_cs_n && $stable(spi_sclk)) [*6] |-> $stable(spi_poci_ff); endproperty
  a_hold: assert property (p_hold) else $error("poci moved");
  property p_rxv; rx_valid_ff |=> !rx_valid_ff; endproperty
  a_rxv: assert property (p_rxv) else $error("rx pulse long");
  property p_fs; $fell(spi_cs_n) |-> ##[1:3] frame_start_ff; endproperty
  a_fs: assert property (p_fs) else $error("no frame start");
  property p_fe; $rose(spi_cs_n) |-> ##[1:3] frame_end_ff; endproperty
  a_fe: assert property (p_fe) else $error("no frame end");
  // Green is dark only in the loader
  property p_boot; dev_boot |=> !led_green_ff; endproperty
  a_boot: assert property (p_boot) else $error("green in boot");
  property p_green; !dev_boot [*2] |=> led_green_ff; endproperty
  a_green: assert property (p_green) else $error("green dark");
  property p_boot_red; dev_boot [*6] |-> led_red_ff != $past(led_red_ff, BLINK_HALF); endproperty
  a_boot_red: assert property (p_boot_red) else $error("red not pulsed");
endmodule // spsp_port_checker
bind spsp_port spsp_port_checker #(.BLINK_HALF(BLINK_HALF)) u_chk (.*);
`default_nettype wire

/* File: tb/spsp_ctl_model.sv */
// Controller model for the far side of the serial port.
// Assumes the bench calls xfer; moves pins on falling sys_clk.
`timescale 1ns/10ps
`default_nettype none
module spsp_ctl_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic     spi_sclk,
  output logic     spi_cs_n,
  output logic     spi_pico,
  input wire logic spi_poci
);
  initial begin
    spi_sclk = 0;
    spi_cs_n = 1;
    spi_pico = 0;
  end
  // One framed transfer of n bits; short n checks refusal of partial bytes
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 0;
    @(negedge sys_clk) spi_cs_n = 0;
    repeat (80) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      spi_sclk = 1;
      spi_pico = tx[15-i];
      repeat (4) @(negedge sys_clk);
      spi_sclk = 0;
      rx = {rx[14:0], spi_poci};
      repeat (4) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    spi_cs_n = 1;
    spi_pico = ~spi_pico; // Released line shows no stale bit
    repeat (100) @(negedge sys_clk);
  endtask
endmodule // spsp_ctl_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial status port.
// Assumes the controller model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk = 0, rst_n = 0, dev_ready = 0, dev_exposing = 0, dev_boot = 0;
  logic [7:0]  tx_byte = 8'ha5;
  logic [15:0] got = 0, r;
  wire logic   sclk, cs_n, pico, poci_d, oe, rxv, txt, red, grn;
  wire logic [7:0] rxb;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  spsp_port #(.BLINK_HALF(4)) u_dut (.sys_clk, .rst_n, .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_pico(pico),
    .spi_poci_ff(poci_d), .spi_poci_oe_ff(oe), .rx_byte_ff(rxb), .rx_valid_ff(rxv), .tx_byte, .tx_taken_ff(txt),
    .frame_start_ff(), .frame_end_ff(), .dev_ready, .dev_exposing, .dev_boot, .led_red_ff(red), .led_green_ff(grn));
  spsp_ctl_model m (.sys_clk, .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_pico(pico), .spi_poci(oe ? poci_d : 1'bz));
  // Next byte offered after each take; received bytes shifted in
  always @(negedge sys_clk) if (txt === 1'b1) tx_byte <= ~tx_byte;
  always @(posedge sys_clk) if (rxv === 1'b1) got <= {got[7:0], rxb};
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Two frames at minimum gap, then a partial byte that must be dropped
  task automatic t_frames();
    // Offered byte flips on every take, the unsent reload at frame end too
    m.xfer(16'h3cc3, 16, r);
    chk("rx", got, 16'h3cc3);
    chk("tx", r, 16'ha55a);
    m.xfer(16'h8001, 16, r);
    chk("rx2", got, 16'h8001);
    chk("tx2", r, 16'h5aa5);
    m.xfer(16'hf000, 4, r);
    chk("partial", got, 16'h8001);
  endtask
  // Indicator level and pulse over ten cycles
  task automatic t_led(logic g);
    logic s0 = 0, s1 = 0;
    repeat (10) begin
      @(negedge sys_clk);
      if (red === 1'b0) s0 = 1;
      if (red === 1'b1) s1 = 1;
    end
    chk("red_pulse", {s0, s1}, 2'b11);
    chk("green", grn, g);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    @(negedge sys_clk);
    chk("init", {red, grn, oe}, 3'b110);
    t_frames();
    dev_ready = 1;
    repeat (2) @(negedge sys_clk);
    chk("idle", {red, grn}, 2'b01);
    dev_exposing = 1;
    t_led(1'b1);
    dev_exposing = 0;
    dev_boot = 1;
    t_led(1'b0);
    dev_boot = 0;
    rst_n = 0;
    repeat (2) @(negedge sys_clk);
    chk("reset", {red, grn}, 2'b11);
    end_sim();
  end
endmodule // tb
`default_nettype wire
